// file: pkg/enc_host_pkg.sv
// shared constants and carrier types for the encoder front end and host port
// assumes one 50 MHz core clock and a synchronous active-low reset
package enc_host_pkg;
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          STABLE_CLKS     = 8;             // least dwell per encoder state
  localparam logic [3:0]  STABLE_CNT_MAX  = 4'(STABLE_CLKS - 1);
  localparam int          POS_W           = 32;
  localparam logic [31:0] POS_RESET       = 32'h0000_0000;
  localparam int          BUSY_BIT        = 0;             // position of busy in status byte
  localparam int          INDEX_BIT       = 1;             // index captured flag
  localparam int          FIFO_FULL_BIT   = 2;             // word buffer full
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [1:0]  BUF_DEPTH       = 2'h2;

  // one byte written by the host, with its port choice
  typedef struct packed {
    logic       is_data;   // port_choice high: data port
    logic [7:0] value;
  } host_word_t;

  // qualified, stable encoder sample
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic index_n;
  } enc_state_t;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b10
  } bus_state_t;
endpackage

// file: src/enc_host_port.sv
// quadrature encoder decoder with index capture and 8-bit asynchronous host port
// assumes host strobes and encoder pins are asynchronous; the core drains written words
`timescale 1ns/1ps

// Functional notes
// RQ1 - capture position when index, A, B all low
// RQ2 - index held high when unused
// RQ3 - A leading B counts forward
// RQ4 - state recognized after eight stable clocks
// RQ5 - every phase edge is one count
// RQ6 - eight-bit bidirectional host data bus
// RQ7 - strobes honoured only with chip select low
// RQ8 - read drives status or data per port_choice
// RQ9 - write takes command or data per port_choice
// RQ10 - port_choice low command, high data
// RQ11 - host writes commands with port_choice low
// RQ12 - busy visible only in status byte
// RQ13 - busy set before any later status read
// RQ14 - all encoder inputs synchronized first
// RQ15 - position steps up or down per edge
// RQ16 - status read from command port
// RQ17 - data transfers use the data port
module enc_host_port
(
  input  wire logic                     CORE_CLK_I,
  input  wire logic                     RST_B_I,
  input  wire logic                     ENC_A_I,
  input  wire logic                     ENC_B_I,
  input  wire logic                     ENC_INDEX_B_I,
  input  wire logic                     CS_B_I,
  input  wire logic                     RD_B_I,
  input  wire logic                     WR_B_I,
  input  wire logic                     PORT_CHOICE_I,
  input  wire logic [7:0]               HOST_BUS_I,
  output logic      [7:0]               HOST_BUS_O,
  output logic                          HOST_BUS_OE_B_O,
  input  wire logic                     INDEX_ARM_I,
  input  wire logic [7:0]               RD_DATA_I,
  input  wire logic                     BUSY_CLR_I,
  output logic      [8:0]               WR_WORD_O,
  output logic                          WR_VALID_O,
  input  wire logic                     WR_READY_I,
  output logic      [31:0]              POSITION_O,
  output logic      [31:0]              INDEX_POS_O,
  output logic                          INDEX_SEEN_O
);

  // two-flop synchronisers: first stage read only by second stage
  // port choice and host data ride the same two stages, so they stay aligned with the strobes
  logic [14:0] sync1_reg, sync1_next;
  logic [14:0] sync2_reg, sync2_next;
  always_comb
  begin
    sync1_next = {ENC_A_I, ENC_B_I, ENC_INDEX_B_I, CS_B_I, RD_B_I, WR_B_I, PORT_CHOICE_I, HOST_BUS_I}; // RQ14
    sync2_next = sync1_reg;
  end
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_B_I)
    begin
      sync1_reg <= 15'h7e00; // pins idle high, port choice and data low
      sync2_reg <= 15'h7e00;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  enc_host_pkg::enc_state_t raw_enc;
  logic                     cs_b, rd_b, wr_b, port_choice;
  logic [7:0]               host_bus;
  assign raw_enc     = enc_host_pkg::enc_state_t'(sync2_reg[14:12]);
  assign cs_b        = sync2_reg[11];
  assign rd_b        = sync2_reg[10];
  assign wr_b        = sync2_reg[9];
  assign port_choice = sync2_reg[8];
  assign host_bus    = sync2_reg[7:0];

  // dwell filter: a new encoder state is taken only after eight equal samples
  enc_host_pkg::enc_state_t cand_reg, cand_next, stable_reg, stable_next;
  logic [3:0]               dwell_reg, dwell_next;
  logic [31:0]              pos_reg, pos_next, idx_reg, idx_next;
  logic                     seen_reg, seen_next;
  logic                     arm_reg, arm_next;
  always_comb
  begin
    cand_next   = raw_enc;
    stable_next = stable_reg;
    dwell_next  = dwell_reg;
    pos_next    = pos_reg;
    idx_next    = idx_reg;
    seen_next   = seen_reg;
    arm_next    = arm_reg | INDEX_ARM_I;
    if (raw_enc != cand_reg)
      dwell_next = 4'h0;
    else if (dwell_reg < enc_host_pkg::STABLE_CNT_MAX)
      dwell_next = dwell_reg + 4'h1;
    else
      stable_next = cand_reg; // RQ4
    // gray-code step: A leads B means forward; invalid double steps are dropped
    if (stable_next.phase_a != stable_reg.phase_a && stable_next.phase_b == stable_reg.phase_b) // RQ5
    begin
      if (stable_next.phase_a != stable_reg.phase_b)
        pos_next = pos_reg + 32'h1; // RQ3 RQ15
      else
        pos_next = pos_reg - 32'h1; // RQ15
    end
    else if (stable_next.phase_b != stable_reg.phase_b && stable_next.phase_a == stable_reg.phase_a) // RQ5
    begin
      if (stable_next.phase_b == stable_reg.phase_a)
        pos_next = pos_reg + 32'h1; // RQ3
      else
        pos_next = pos_reg - 32'h1; // RQ15
    end
    // capture only on the all-low state; an unused index sits high so never fires (RQ2)
    if (arm_reg && !stable_reg.phase_a && !stable_reg.phase_b && !stable_reg.index_n) // RQ1
    begin
      idx_next  = pos_reg;
      seen_next = 1'b1;
      arm_next  = 1'b0;
    end
  end
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_B_I)
    begin
      cand_reg   <= 3'h7;
      stable_reg <= 3'h7;
      dwell_reg  <= 4'h0;
      pos_reg    <= enc_host_pkg::POS_RESET;
      idx_reg    <= enc_host_pkg::POS_RESET;
      seen_reg   <= 1'b0;
      arm_reg    <= 1'b0;
    end
    else
    begin
      cand_reg   <= cand_next;
      stable_reg <= stable_next;
      dwell_reg  <= dwell_next;
      pos_reg    <= pos_next;
      idx_reg    <= idx_next;
      seen_reg   <= seen_next;
      arm_reg    <= arm_next;
    end
  end
  assign POSITION_O   = pos_reg;
  assign INDEX_POS_O  = idx_reg;
  assign INDEX_SEEN_O = seen_reg;

  // host strobe sequencer; port choice and data share the strobes' delay
  enc_host_pkg::bus_state_t bus_reg, bus_next;
  logic [7:0]               dout_reg, dout_next;
  logic                     oe_b_reg, oe_b_next;
  logic                     busy_reg, busy_next;
  enc_host_pkg::host_word_t buf_reg [2];
  enc_host_pkg::host_word_t buf_next [2];
  logic [1:0]               cnt_reg, cnt_next;
  logic                     push, pop;
  logic                     valid_reg, valid_next;
  enc_host_pkg::host_word_t in_word;
  logic [7:0]               status;

  always_comb
  begin
    status                              = enc_host_pkg::STATUS_RESET;
    status[enc_host_pkg::BUSY_BIT]      = busy_reg; // RQ12
    status[enc_host_pkg::INDEX_BIT]     = seen_reg;
    status[enc_host_pkg::FIFO_FULL_BIT] = (cnt_reg == enc_host_pkg::BUF_DEPTH);
  end

  always_comb
  begin
    bus_next      = bus_reg;
    dout_next     = dout_reg;
    oe_b_next     = 1'b1;
    push          = 1'b0;
    in_word       = '{is_data: port_choice, value: host_bus};
    case (bus_reg)
      enc_host_pkg::BUS_IDLE:
      begin
        if (!cs_b && !rd_b) // RQ7
        begin
          bus_next  = enc_host_pkg::BUS_READ;
          oe_b_next = 1'b0; // RQ6
          dout_next = port_choice ? RD_DATA_I : status; // RQ8 RQ10 RQ16 RQ17
        end
        else if (!cs_b && !wr_b) // RQ7
          bus_next = enc_host_pkg::BUS_WRITE;
      end
      enc_host_pkg::BUS_READ:
      begin
        oe_b_next = rd_b | cs_b ? 1'b1 : 1'b0;
        if (rd_b || cs_b)
          bus_next = enc_host_pkg::BUS_IDLE;
      end
      enc_host_pkg::BUS_WRITE:
      begin
        // byte is latched at the rising write edge, when host data is settled
        if (wr_b || cs_b)
        begin
          bus_next = enc_host_pkg::BUS_IDLE;
          push     = 1'b1; // RQ9 RQ11
        end
      end
      default:
        bus_next = enc_host_pkg::BUS_IDLE;
    endcase
  end

  // two-entry buffer; a full buffer drops the write but busy stays high to warn the host
  assign pop = WR_VALID_O && WR_READY_I;
  always_comb
  begin
    buf_next = buf_reg;
    cnt_next = cnt_reg;
    if (pop)
    begin
      buf_next[0] = buf_reg[1];
      cnt_next    = cnt_next - 2'h1;
    end
    if (push && cnt_next < enc_host_pkg::BUF_DEPTH)
    begin
      buf_next[cnt_next[0]] = in_word;
      cnt_next              = cnt_next + 2'h1;
    end
    // set wins over clear so a write landing with the clear is not lost
    busy_next = push ? 1'b1 : (BUSY_CLR_I ? 1'b0 : busy_reg); // RQ13
    valid_next = (cnt_next != 2'h0); // registered so the output leaves a flop
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_B_I)
    begin
      bus_reg    <= enc_host_pkg::BUS_IDLE;
      dout_reg   <= 8'h00;
      oe_b_reg   <= 1'b1;
      busy_reg   <= 1'b0;
      buf_reg[0] <= '0;
      buf_reg[1] <= '0;
      cnt_reg    <= 2'h0;
      valid_reg  <= 1'b0;
    end
    else
    begin
      bus_reg    <= bus_next;
      dout_reg   <= dout_next;
      oe_b_reg   <= oe_b_next;
      busy_reg   <= busy_next;
      buf_reg    <= buf_next;
      cnt_reg    <= cnt_next;
      valid_reg  <= valid_next;
    end
  end

  assign HOST_BUS_O      = dout_reg;
  assign HOST_BUS_OE_B_O = oe_b_reg;
  assign WR_WORD_O       = buf_reg[0];
  assign WR_VALID_O      = valid_reg;

endmodule // enc_host_port

// file: sim/enc_host_port_sva.sv
// port checker for the encoder front end and host port
// assumes it is bound onto enc_host_port and shares its one clock
`timescale 1ns/1ps
module enc_host_port_chk
(
  input wire logic        CORE_CLK_I,
  input wire logic        RST_B_I,
  input wire logic        ENC_A_I,
  input wire logic        ENC_B_I,
  input wire logic        ENC_INDEX_B_I,
  input wire logic        CS_B_I,
  input wire logic        RD_B_I,
  input wire logic        WR_B_I,
  input wire logic        PORT_CHOICE_I,
  input wire logic [7:0]  HOST_BUS_O,
  input wire logic        HOST_BUS_OE_B_O,
  input wire logic        WR_VALID_O,
  input wire logic [31:0] POSITION_O,
  input wire logic [31:0] INDEX_POS_O,
  input wire logic        INDEX_SEEN_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // read strobe held long enough to cross the synchronisers
  sequence rd_held;
    (!CS_B_I && !RD_B_I && WR_B_I)[*5];
  endsequence
  // one encoder edge followed by the least dwell
  sequence enc_edge;
    $changed({ENC_A_I, ENC_B_I}) ##1 $stable({ENC_A_I, ENC_B_I})[*8];
  endsequence
  AST_CS_GATE: assert property (CS_B_I[*5] |-> HOST_BUS_OE_B_O)
    else $error("bus driven while deselected");
  AST_RD_DRIVE: assert property (rd_held |-> !HOST_BUS_OE_B_O)
    else $error("read strobe not answered");
  AST_STATUS_PAD: assert property (rd_held ##0 !PORT_CHOICE_I |-> HOST_BUS_O[7:3] == 5'h00)
    else $error("status byte upper bits set");
  AST_WR_PUSH: assert property ($rose(WR_B_I) && !CS_B_I |-> ##[3:6] WR_VALID_O)
    else $error("written byte not offered");
  AST_POS_STEP: assert property ($changed(POSITION_O) |-> (POSITION_O - $past(POSITION_O) == 32'h1) ||
                                ($past(POSITION_O) - POSITION_O == 32'h1))
    else $error("position moved by more than one");
  AST_POS_SETTLE: assert property ($changed({ENC_A_I, ENC_B_I}) |-> ##1 $stable(POSITION_O)[*7])
    else $error("encoder state taken too early");
  AST_POS_DUE: assert property (enc_edge |-> ##[0:8] $changed(POSITION_O))
    else $error("stable encoder edge not counted");
  AST_INDEX_CAP: assert property ($rose(INDEX_SEEN_O) |-> INDEX_POS_O == POSITION_O &&
                                 !$past(ENC_INDEX_B_I, 2) && !$past(ENC_A_I, 2) && !$past(ENC_B_I, 2))
    else $error("index capture without all inputs low");
endmodule // enc_host_port_chk

bind enc_host_port enc_host_port_chk i_enc_host_port_chk (.*);

// file: sim/quad_enc_model.sv
// quadrature encoder with index line, far side of the decoder
// assumes the bench calls its tasks; pins move on falling edges
`timescale 1ns/1ps
module quad_enc_model
(
  input  wire logic clk_i,
  output logic      a_o,
  output logic      b_o,
  output logic      index_b_o
);
  logic [1:0] ph;
  // start in state 11 to match the synchroniser reset fill
  initial
  begin
    ph = 2'h2;
    {a_o, b_o} = 2'h3;
    index_b_o = 1'b1;
  end
  // a leads b going forward; dwell is twice the least
  task automatic step(input logic fwd);
    ph = fwd ? ph + 2'h1 : ph - 2'h1;
    @(negedge clk_i);
    case (ph)
      2'h0: {a_o, b_o} = 2'h0;
      2'h1: {a_o, b_o} = 2'h2;
      2'h2: {a_o, b_o} = 2'h3;
      default: {a_o, b_o} = 2'h1;
    endcase
    repeat (16) @(negedge clk_i);
  endtask
  task automatic idx(input logic lvl);
    @(negedge clk_i);
    index_b_o = lvl;
    repeat (20) @(negedge clk_i);
  endtask
endmodule // quad_enc_model

// file: sim/testbench.sv
// self-checking bench for enc_host_port
// assumes quad_enc_model drives the encoder pins; host pins come from here
`timescale 1ns/1ps
module testbench;
  logic        clk, rst_b, cs_b, rd_b, wr_b, ps, arm, bclr, rdy;
  logic        oe_b, enc_a, enc_b, enc_i, wvld, seen, o;
  logic [7:0]  hbus, rdat, hout, d;
  logic [8:0]  wword;
  logic [31:0] pos, ipos;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  enc_host_port i_enc_host_port (.CORE_CLK_I(clk), .RST_B_I(rst_b), .ENC_A_I(enc_a), .ENC_B_I(enc_b),
    .ENC_INDEX_B_I(enc_i), .CS_B_I(cs_b), .RD_B_I(rd_b), .WR_B_I(wr_b), .PORT_CHOICE_I(ps),
    .HOST_BUS_I(hbus), .HOST_BUS_O(hout), .HOST_BUS_OE_B_O(oe_b), .INDEX_ARM_I(arm), .RD_DATA_I(rdat),
    .BUSY_CLR_I(bclr), .WR_WORD_O(wword), .WR_VALID_O(wvld), .WR_READY_I(rdy), .POSITION_O(pos),
    .INDEX_POS_O(ipos), .INDEX_SEEN_O(seen));
  quad_enc_model i_quad_enc_model (.clk_i(clk), .a_o(enc_a), .b_o(enc_b), .index_b_o(enc_i));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // strobe held past the synchronisers, sampled before release
  task automatic host_rd(input logic c, input logic p);
    @(negedge clk);
    {cs_b, ps, rd_b} = {c, p, 1'b0};
    repeat (6) @(negedge clk);
    {d, o} = {hout, oe_b};
    {cs_b, rd_b} = 2'h3;
    repeat (6) @(negedge clk);
  endtask
  task automatic host_wr(input logic c, input logic p, input logic [7:0] v);
    @(negedge clk);
    {cs_b, ps, hbus, wr_b} = {c, p, v, 1'b0};
    repeat (4) @(negedge clk);
    wr_b = 1'b1;
    repeat (5) @(negedge clk);
    cs_b = 1'b1;
  endtask
  // index low away from state 00 must not capture
  task automatic t_index_miss;
    i_quad_enc_model.idx(1'b0);
    chk(32'(seen), 32'h0);
    i_quad_enc_model.idx(1'b1);
  endtask
  task automatic t_count;
    repeat (4) i_quad_enc_model.step(1'b1);
    chk(pos, 32'h4);
    repeat (6) i_quad_enc_model.step(1'b0);
    chk(pos, 32'hffff_fffe);
  endtask
  // all-low state while disarmed must wait for the arm pulse
  task automatic t_index_hit;
    i_quad_enc_model.idx(1'b0);
    chk(32'(seen), 32'h0);
    arm = 1'b1;
    @(negedge clk);
    arm = 1'b0;
    repeat (3) @(negedge clk);
    chk(32'(seen), 32'h1);
    chk(ipos, 32'hffff_fffe);
    i_quad_enc_model.idx(1'b1);
  endtask
  task automatic t_reads;
    host_rd(1'b1, 1'b0);
    chk(32'(o), 32'h1);
    host_rd(1'b0, 1'b0);
    chk(32'(o), 32'h0);
    chk(32'(d), 32'h02);
    rdat = 8'ha5;
    host_rd(1'b0, 1'b1);
    chk(32'(d), 32'ha5);
  endtask
  // receiver stalled: third byte meets a full buffer and is lost
  task automatic t_writes;
    host_wr(1'b1, 1'b0, 8'h11);
    chk(32'(wvld), 32'h0);
    host_wr(1'b0, 1'b0, 8'h3c);
    host_wr(1'b0, 1'b1, 8'hc3);
    host_wr(1'b0, 1'b1, 8'h5a);
    host_rd(1'b0, 1'b0);
    chk(32'(d), 32'h07);
    chk(32'(wword), 32'h03c);
    rdy = 1'b1;
    @(negedge clk);
    rdy = 1'b0;
    chk(32'(wword), 32'h1c3);
    rdy = 1'b1;
    repeat (3) @(negedge clk);
    chk(32'(wvld), 32'h0);
    bclr = 1'b1;
    @(negedge clk);
    bclr = 1'b0;
    host_rd(1'b0, 1'b0);
    chk(32'(d), 32'h02);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, well above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  initial
  begin
    {rst_b, cs_b, rd_b, wr_b, ps, arm, bclr, rdy} = 8'h70;
    {hbus, rdat} = 16'h0000;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    t_index_miss;
    t_count;
    t_index_hit;
    t_reads;
    t_writes;
    print_verdict;
  end
endmodule // testbench
